/* File: logic/link_monitor_pkg.sv */
// Purpose: Shared constants and types for the link error monitor
// Assumes: 20 MHz core clock; registers are 8 bits wide
// Notes:   Offsets are the register addresses of the control channel
package link_monitor_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LINK_CTRL = 8'h04;
  localparam logic [7:0] OFS_OPTIONS   = 8'h06;
  localparam logic [7:0] OFS_SYNC_FILT = 8'h08;
  localparam logic [7:0] OFS_ERR_LIMIT = 8'h0C;
  localparam logic [7:0] OFS_DEC_CNT   = 8'h0D;
  localparam logic [7:0] OFS_PAT_CNT   = 8'h0E;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         BIT_PAT_EN    = 5;
  localparam int         BIT_AUTO_CLR  = 6;
  localparam int         BIT_HS_OFF    = 0;
  localparam int         BIT_VS_OFF    = 1;
  localparam int         BIT_PIN_LVL   = 7;
  localparam logic [7:0] REG_RST       = 8'h00;
  localparam logic [7:0] ERR_LIMIT_RST = 8'h00;
  localparam logic [7:0] CNT_ZERO      = 8'h00;
  localparam logic [7:0] CNT_MAX       = 8'hFF;

  // ----------------------------------------------------------------
  // Timing and link quality figures
  // ----------------------------------------------------------------
  localparam int CLK_NS        = 50;
  localparam int AUTO_CLR_NS   = 1000;
  localparam int AUTO_CLR_CYC  = (AUTO_CLR_NS / CLK_NS < 1) ? 1 : AUTO_CLR_NS / CLK_NS;
  localparam int ERR_WIN_SYMS  = 16;
  localparam int ERR_RATE_DIV  = 4;
  localparam int RELOCK_SYMS   = 32;
  localparam int PRBS_ORDER    = 7;

  typedef enum logic {LOCK_SEARCH, LOCK_HELD} lock_state_t;

endpackage : link_monitor_pkg

/* File: logic/link_error_monitor.sv */
// Purpose: Link quality monitor: decode error count, error pin, PRBS check, sync filters
// Assumes: One decoded symbol per accepted cycle; register port is the decoded UART channel
// Notes:   Decoded symbols pass through a FIFO toward the pixel side
`timescale 1ns/1ns

module sync_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_r;
  logic [AW:0]      rdPtr_r;

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("sync_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  assign inReady  = (wrPtr_r[AW] == rdPtr_r[AW]) || (wrPtr_r[AW-1:0] != rdPtr_r[AW-1:0]);
  assign outValid = (wrPtr_r != rdPtr_r);
  assign outData  = mem[rdPtr_r[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (inValid && inReady) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPtr_r <= '0;
    end else if (inValid && inReady) begin
      wrPtr_r <= wrPtr_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdPtr_r <= '0;
    end else if (outValid && outReady) begin
      rdPtr_r <= rdPtr_r + 1'b1;
    end
  end
endmodule : sync_fifo

module link_error_monitor
  import link_monitor_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       symValid,
  output logic            symReady,
  input  wire logic [7:0] symData,
  input  wire logic       symDecodeErr,
  input  wire logic       symParityErr,
  input  wire logic       symHsync,
  input  wire logic       symVsync,
  output logic            pixValid,
  input  wire logic       pixReady,
  output logic      [7:0] pixData,
  output logic            pixHsync,
  output logic            pixVsync,
  input  wire logic       regWr,
  input  wire logic       regRd,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  output logic            regRdValid,
  input  wire logic       errPinIn,
  output logic            errPinOut,
  output logic            errPinOeN,
  output logic            videoLock
);

  generate
    if (AUTO_CLR_CYC > 255 || FIFO_DEPTH < 2) begin : g_bad_cfg
      $error("link_error_monitor configuration out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Returns {error bits, new history}; taps x^7 + x^6 + 1, MSB first
  function automatic logic [10:0] prbs_check(input logic [6:0] hist, input logic [7:0] data);
    logic [6:0] h;
    logic [3:0] n;
    logic       pred;
    h = hist;
    n = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      pred = h[6] ^ h[5];
      if (pred != data[i]) begin
        n = n + 4'h1;
      end
      h = {h[5:0], data[i]};
    end
    return {n, h};
  endfunction : prbs_check

  // Passes a level only once seen on two samples in a row
  function automatic logic sync_filter(input logic off, input logic cur, input logic prev,
                                       input logic held);
    if (off || cur == prev) begin
      return cur;
    end
    return held;
  endfunction : sync_filter

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  linkCtrl_r;
  logic [7:0]  options_r;
  logic [7:0]  syncFilt_r;
  logic [7:0]  errLimit_r;
  logic [7:0]  decCnt_r;
  logic [7:0]  patCnt_r;
  logic [7:0]  regRdData_r;
  logic        regRdValid_r;
  logic        patEn;
  logic        autoEn;
  logic        accept;
  logic        rdDec;
  logic        rdPat;

  assign patEn  = linkCtrl_r[BIT_PAT_EN];
  assign autoEn = options_r[BIT_AUTO_CLR];
  assign accept = symValid && symReady;
  assign rdDec  = regRd && regAddr == OFS_DEC_CNT;
  assign rdPat  = regRd && regAddr == OFS_PAT_CNT;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      linkCtrl_r <= REG_RST;
      options_r  <= REG_RST;
      syncFilt_r <= REG_RST;
      errLimit_r <= ERR_LIMIT_RST;
    end else if (regWr) begin
      case (regAddr)
        OFS_LINK_CTRL: linkCtrl_r <= regWrData;
        OFS_OPTIONS:   options_r  <= regWrData;
        OFS_SYNC_FILT: syncFilt_r <= regWrData;
        OFS_ERR_LIMIT: errLimit_r <= regWrData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      regRdData_r  <= CNT_ZERO;
      regRdValid_r <= 1'b0;
    end else begin
      regRdValid_r <= regRd;
      if (regRd) begin
        case (regAddr)
          OFS_LINK_CTRL: regRdData_r <= linkCtrl_r;
          OFS_OPTIONS:   regRdData_r <= options_r;
          OFS_SYNC_FILT: regRdData_r <= {errPinIn, syncFilt_r[BIT_PIN_LVL-1:0]};
          OFS_ERR_LIMIT: regRdData_r <= errLimit_r;
          OFS_DEC_CNT:   regRdData_r <= decCnt_r;
          OFS_PAT_CNT:   regRdData_r <= patCnt_r;
          default:       regRdData_r <= CNT_ZERO;
        endcase
      end
    end
  end

  assign regRdData  = regRdData_r;
  assign regRdValid = regRdValid_r;

  // ----------------------------------------------------------------
  // Lock tracking
  // ----------------------------------------------------------------
  localparam int         WIN_W      = $clog2(ERR_WIN_SYMS);
  localparam int         RUN_W      = $clog2(RELOCK_SYMS);
  localparam logic [WIN_W-1:0] WIN_LAST   = WIN_W'(ERR_WIN_SYMS - 1);
  localparam logic [WIN_W:0]   WIN_ERR_LIM = (WIN_W + 1)'(ERR_WIN_SYMS / ERR_RATE_DIV);
  localparam logic [RUN_W-1:0] RUN_LAST   = RUN_W'(RELOCK_SYMS - 1);

  lock_state_t      lockState_r;
  logic [WIN_W-1:0] winCnt_r;
  logic [WIN_W:0]   winErr_r;
  logic [RUN_W-1:0] goodRun_r;
  logic             symErr;
  logic             lockGain;
  logic [WIN_W:0]   winErrNxt;

  assign symErr    = !patEn && (symDecodeErr || symParityErr);
  assign lockGain  = lockState_r == LOCK_SEARCH && accept && !symErr && goodRun_r == RUN_LAST;
  assign winErrNxt = winErr_r + (WIN_W + 1)'(symErr);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lockState_r <= LOCK_SEARCH;
      winCnt_r    <= '0;
      winErr_r    <= '0;
      goodRun_r   <= '0;
    end else if (accept) begin
      case (lockState_r)
        LOCK_HELD: begin
          winCnt_r <= winCnt_r + 1'b1;
          winErr_r <= (winCnt_r == WIN_LAST) ? '0 : winErrNxt;
          if (winCnt_r == WIN_LAST && winErrNxt >= WIN_ERR_LIM) begin
            lockState_r <= LOCK_SEARCH;
            goodRun_r   <= '0;
          end
        end
        LOCK_SEARCH: begin
          goodRun_r <= symErr ? '0 : goodRun_r + 1'b1;
          if (lockGain) begin
            lockState_r <= LOCK_HELD;
            winCnt_r    <= '0;
            winErr_r    <= '0;
          end
        end
        default: lockState_r <= LOCK_SEARCH;
      endcase
    end
  end

  assign videoLock = lockState_r == LOCK_HELD;

  // ----------------------------------------------------------------
  // Decode error counter and auto clear
  // ----------------------------------------------------------------
  localparam logic [7:0] AUTO_LAST = 8'(AUTO_CLR_CYC - 1);

  logic       decInc;
  logic       autoClr;
  logic [7:0] lowCnt_r;
  logic       errRel_r;

  assign decInc  = accept && videoLock && symErr;
  assign autoClr = autoEn && !patEn && !errRel_r && lowCnt_r == AUTO_LAST;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      decCnt_r <= CNT_ZERO;
    end else if (patEn) begin
      decCnt_r <= CNT_ZERO;
    end else if (lockGain || rdDec || autoClr) begin
      decCnt_r <= decInc ? 8'h01 : CNT_ZERO;
    end else if (decInc && decCnt_r != CNT_MAX) begin
      decCnt_r <= decCnt_r + 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !autoEn || patEn || errRel_r || autoClr) begin
      lowCnt_r <= CNT_ZERO;
    end else begin
      lowCnt_r <= lowCnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Pattern checker
  // ----------------------------------------------------------------
  logic [6:0]  hist_r;
  logic        patSynced_r;
  logic        patEnD_r;
  logic [10:0] chk;
  logic [8:0]  patSum;
  logic        patInc;

  assign chk    = prbs_check(hist_r, symData);
  assign patInc = accept && patEn && patSynced_r;
  assign patSum = {1'b0, patCnt_r} + {5'h00, chk[10:7]};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hist_r      <= '0;
      patSynced_r <= 1'b0;
      patEnD_r    <= 1'b0;
    end else begin
      patEnD_r <= patEn;
      if (!patEn) begin
        patSynced_r <= 1'b0;
      end else if (accept) begin
        hist_r      <= chk[PRBS_ORDER-1:0];
        patSynced_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      patCnt_r <= CNT_ZERO;
    end else if (rdPat || (patEn && !patEnD_r)) begin
      patCnt_r <= patInc ? {4'h0, chk[10:7]} : CNT_ZERO;
    end else if (patInc) begin
      patCnt_r <= patSum[8] ? CNT_MAX : patSum[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Error pin
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      errRel_r <= 1'b1;
    end else if (patEn) begin
      errRel_r <= patCnt_r == CNT_ZERO;
    end else begin
      errRel_r <= !(decCnt_r > errLimit_r);
    end
  end

  assign errPinOut = 1'b0;
  assign errPinOeN = errRel_r;

  // ----------------------------------------------------------------
  // Sync glitch filters and symbol FIFO
  // ----------------------------------------------------------------
  logic hsPrev_r;
  logic vsPrev_r;
  logic hsFilt_r;
  logic vsFilt_r;
  logic hsNxt;
  logic vsNxt;

  assign hsNxt = sync_filter(syncFilt_r[BIT_HS_OFF], symHsync, hsPrev_r, hsFilt_r);
  assign vsNxt = sync_filter(syncFilt_r[BIT_VS_OFF], symVsync, vsPrev_r, vsFilt_r);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hsPrev_r <= 1'b0;
      vsPrev_r <= 1'b0;
      hsFilt_r <= 1'b0;
      vsFilt_r <= 1'b0;
    end else if (accept) begin
      hsPrev_r <= symHsync;
      vsPrev_r <= symVsync;
      hsFilt_r <= hsNxt;
      vsFilt_r <= vsNxt;
    end
  end

  sync_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .inValid  (symValid),
    .inReady  (symReady),
    .inData   ({hsNxt, vsNxt, symData}),
    .outValid (pixValid),
    .outReady (pixReady),
    .outData  ({pixHsync, pixVsync, pixData})
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_dec_read;
    rdDec && !patEn && !decInc && !lockGain;
  endsequence

  sequence s_released;
    decCnt_r == CNT_ZERO ##1 errRel_r;
  endsequence

  chk_dec_count_step: assert property (decInc && !patEn && !rdDec && !autoClr
      && decCnt_r != CNT_MAX |=> decCnt_r == $past(decCnt_r) + 8'h01)
    else $error("decode count did not step on an error");
  chk_unlock_freeze: assert property (!videoLock && $past(!videoLock)
      |-> decCnt_r <= $past(decCnt_r))
    else $error("decode count grew while unlocked");
  chk_read_release: assert property (s_dec_read |=> s_released)
    else $error("decode read did not clear and release the pin");
  chk_pat_hold_zero: assert property (patEn |=> decCnt_r == CNT_ZERO)
    else $error("decode count not zero in pattern test");
  chk_limit_pin: assert property (!patEn ##1 !patEn && decCnt_r > errLimit_r
      |=> !errPinOeN)
    else $error("error pin not driven above the limit");
  chk_pat_err_pin: assert property (patInc && chk[10:7] != 4'h0 && patEnD_r
      |=> patCnt_r != CNT_ZERO ##1 (!errPinOeN || !patEn))
    else $error("pattern error did not drive the error pin");
  chk_auto_clear: assert property (autoClr |=> decCnt_r <= 8'h01 && lowCnt_r == CNT_ZERO)
    else $error("auto clear did not empty the decode count");
  chk_auto_delay: assert property (autoClr |-> !errRel_r
      && !$past(errRel_r, AUTO_CLR_CYC - 1) && $past(autoEn, AUTO_CLR_CYC - 1))
    else $error("auto clear fired early");
  chk_no_auto_pat: assert property (patEn || !autoEn |=> lowCnt_r == CNT_ZERO)
    else $error("auto clear timer ran while barred");
  chk_filter_glitch: assert property (accept && !syncFilt_r[BIT_HS_OFF]
      && hsNxt != hsFilt_r |-> symHsync == hsPrev_r)
    else $error("single-sample sync pulse passed the filter");

endmodule : link_error_monitor

/* File: dv/serializer_model.sv */
// Purpose: Far-end serializer model driving the decoded symbol stream
// Assumes: Symbols change on the falling clock edge
// Notes:   Released data shows the inverse of the last byte
`timescale 1ns/1ns

module serializer_model (
  input  wire logic       core_clk,
  output logic            symValid,
  input  wire logic       symReady,
  output logic      [7:0] symData,
  output logic            symDecodeErr,
  output logic            symParityErr,
  output logic            symHsync,
  output logic            symVsync
);
  logic [6:0] lfsr;

  initial begin
    lfsr         = 7'h7F;
    symValid     = 1'b0;
    symData      = 8'h00;
    symDecodeErr = 1'b0;
    symParityErr = 1'b0;
    symHsync     = 1'b0;
    symVsync     = 1'b0;
  end

  // ----------------------------------------------------------------
  // Symbol transfer
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] d, input logic de, input logic pe, input logic s);
    @(negedge core_clk);
    symValid     = 1'b1;
    symData      = d;
    symDecodeErr = de;
    symParityErr = pe;
    symHsync     = s;
    symVsync     = s;
    do @(posedge core_clk); while (symReady !== 1'b1);
  endtask : send

  task automatic idle();
    @(negedge core_clk);
    symValid     = 1'b0;
    symData      = ~symData;
    symDecodeErr = 1'b0;
    symParityErr = 1'b0;
  endtask : idle

  // ----------------------------------------------------------------
  // Pattern generator, MSB first; bit flipAt is inverted
  // ----------------------------------------------------------------
  task automatic prbs(input int n, input int flipAt);
    logic [7:0] b;
    logic       nb;
    for (int i = 0; i < n; i++) begin
      for (int j = 7; j >= 0; j--) begin
        nb   = lfsr[6] ^ lfsr[5];
        lfsr = {lfsr[5:0], nb};
        b[j] = nb ^ ((i * 8 + 7 - j) == flipAt);
      end
      send(b, i[0], 1'b0, 1'b0);
    end
  endtask : prbs
endmodule : serializer_model

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench for the link error monitor
// Assumes: Serializer model drives the symbols; bench drives registers
// Notes:   Inputs change on the falling clock edge
`timescale 1ns/1ns

module tb_top;
  import link_monitor_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] w; logic [7:0] m; logic [7:0] e;} row_t;

  logic       core_clk  = 1'b0;
  logic       rst       = 1'b1;
  logic       pixReady  = 1'b1;
  logic       regWr     = 1'b0;
  logic       regRd     = 1'b0;
  logic [7:0] regAddr   = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic       hsSeen    = 1'b0;
  logic       vsSeen    = 1'b0;
  logic       symValid, symReady, symDecodeErr, symParityErr, symHsync, symVsync;
  logic       pixValid, pixHsync, pixVsync, regRdValid, errPinOut, errPinOeN, videoLock;
  logic       errPinIn;
  logic [7:0] symData, pixData, regRdData;
  int         n_errors  = 0;
  int         checked   = 0;
  int         cycles    = 0;
  int         n;
  row_t       rows [17] = '{
    {1'b0, 8'h04, 8'h00, 8'hFF, 8'h00}, {1'b0, 8'h06, 8'h00, 8'h40, 8'h00},
    {1'b0, 8'h08, 8'h00, 8'h83, 8'h80}, {1'b0, 8'h0C, 8'h00, 8'hFF, 8'h00},
    {1'b0, 8'h0D, 8'h00, 8'hFF, 8'h00}, {1'b0, 8'h0E, 8'h00, 8'hFF, 8'h00},
    {1'b0, 8'h20, 8'h00, 8'hFF, 8'h00}, {1'b1, 8'h04, 8'h5A, 8'hFF, 8'h5A},
    {1'b1, 8'h04, 8'h00, 8'hFF, 8'h00}, {1'b1, 8'h06, 8'h40, 8'h40, 8'h40},
    {1'b1, 8'h06, 8'h00, 8'h40, 8'h00}, {1'b1, 8'h08, 8'h03, 8'h83, 8'h83},
    {1'b1, 8'h08, 8'h00, 8'h83, 8'h80}, {1'b1, 8'h0D, 8'hFF, 8'hFF, 8'h00},
    {1'b1, 8'h0E, 8'h55, 8'hFF, 8'h00}, {1'b1, 8'h30, 8'h11, 8'hFF, 8'h00},
    {1'b1, 8'h0C, 8'h02, 8'hFF, 8'h02}
  };

  always #25 core_clk = ~core_clk;
  // Open-drain pin with pull-up
  assign errPinIn = errPinOeN ? 1'b1 : errPinOut;

  serializer_model serializer_model_i (.core_clk(core_clk), .symValid(symValid),
    .symReady(symReady), .symData(symData), .symDecodeErr(symDecodeErr),
    .symParityErr(symParityErr), .symHsync(symHsync), .symVsync(symVsync));

  link_error_monitor #(.FIFO_DEPTH(16)) link_error_monitor_i (.core_clk(core_clk), .rst(rst),
    .symValid(symValid), .symReady(symReady), .symData(symData),
    .symDecodeErr(symDecodeErr), .symParityErr(symParityErr), .symHsync(symHsync),
    .symVsync(symVsync), .pixValid(pixValid), .pixReady(pixReady), .pixData(pixData),
    .pixHsync(pixHsync), .pixVsync(pixVsync), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .errPinIn(errPinIn), .errPinOut(errPinOut),
    .errPinOeN(errPinOeN), .videoLock(videoLock));

  always @(posedge core_clk) begin
    if (pixValid && pixReady) begin
      hsSeen <= hsSeen | pixHsync;
      vsSeen <= vsSeen | pixVsync;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checked %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regAddr   = a;
    regWrData = d;
    regWr     = 1'b1;
    @(negedge core_clk);
    regWr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge core_clk);
    regAddr = a;
    regRd   = 1'b1;
    @(negedge core_clk);
    regRd = 1'b0;
    chk("regRdValid", {7'h00, regRdValid}, 8'h01);
    chk("regRdData", regRdData & m, e);
  endtask : rd

  task automatic pin(input logic v, input int lim);
    n = 0;
    while (errPinOeN !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk("errPinOeN", {7'h00, errPinOeN}, {7'h00, v});
  endtask : pin

  task automatic win(input int de, input int pe, input int len);
    for (int i = 0; i < len; i++)
      serializer_model_i.send(i[7:0], i < de, i >= de && i < de + pe, 1'b0);
    serializer_model_i.idle();
    repeat (4) @(negedge core_clk);
  endtask : win

  task automatic pulse(input logic [4:0] p, input logic expHs, input logic expVs);
    hsSeen = 1'b0;
    vsSeen = 1'b0;
    for (int i = 0; i < 5; i++) serializer_model_i.send(8'h00, 1'b0, 1'b0, p[i]);
    serializer_model_i.idle();
    repeat (10) @(negedge core_clk);
    chk("pixHsync", {7'h00, hsSeen}, {7'h00, expHs});
    chk("pixVsync", {7'h00, vsSeen}, {7'h00, expVs});
  endtask : pulse

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    chk("videoLock", {7'h00, videoLock}, 8'h00);
    chk("errPinOeN", {7'h00, errPinOeN}, 8'h01);
    chk("errPinOut", {7'h00, errPinOut}, 8'h00);
    chk("symReady", {7'h00, symReady}, 8'h01);
    for (int i = 0; i < 17; i++) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].m, rows[i].e);
    end
    $display("test registers done");
    win(0, 0, 32);
    chk("videoLock", {7'h00, videoLock}, 8'h01);
    win(2, 2, 16);
    chk("videoLock", {7'h00, videoLock}, 8'h00);
    win(4, 0, 8);
    chk("errPinOeN", {7'h00, errPinOeN}, 8'h00);
    win(0, 0, 32);
    chk("videoLock", {7'h00, videoLock}, 8'h01);
    chk("errPinOeN", {7'h00, errPinOeN}, 8'h01);
    rd(8'h0D, 8'hFF, 8'h00);
    $display("test lock done");
    win(2, 0, 16);
    chk("errPinOeN", {7'h00, errPinOeN}, 8'h01);
    win(1, 0, 16);
    chk("errPinOeN", {7'h00, errPinOeN}, 8'h00);
    rd(8'h0D, 8'hFF, 8'h03);
    repeat (2) @(negedge core_clk);
    chk("errPinOeN", {7'h00, errPinOeN}, 8'h01);
    $display("test threshold done");
    pulse(5'b00010, 1'b0, 1'b0);
    pulse(5'b00110, 1'b1, 1'b1);
    wr(8'h08, 8'h01);
    pulse(5'b00010, 1'b1, 1'b0);
    wr(8'h08, 8'h03);
    pulse(5'b00010, 1'b1, 1'b1);
    $display("test filters done");
    pixReady = 1'b0;
    win(0, 0, 16);
    chk("symReady", {7'h00, symReady}, 8'h00);
    chk("pixValid", {7'h00, pixValid}, 8'h01);
    chk("pixData", pixData, 8'h00);
    pixReady = 1'b1;
    repeat (20) @(negedge core_clk);
    chk("pixValid", {7'h00, pixValid}, 8'h00);
    $display("test buffer done");
    wr(8'h0C, 8'h00);
    wr(8'h06, 8'h40);
    serializer_model_i.send(8'h00, 1'b1, 1'b0, 1'b0);
    serializer_model_i.idle();
    pin(1'b0, 10);
    pin(1'b1, 40);
    chk("autoDelay", {7'h00, n >= 20 && n <= 24}, 8'h01);
    rd(8'h0D, 8'hFF, 8'h00);
    $display("test auto clear done");
    // Pattern check is enabled before the far end starts its generator, filters are already off
    wr(8'h04, 8'h20);
    serializer_model_i.prbs(8, -1);
    serializer_model_i.idle();
    rd(8'h0E, 8'hFF, 8'h00);
    rd(8'h0D, 8'hFF, 8'h00);
    chk("errPinOeN", {7'h00, errPinOeN}, 8'h01);
    serializer_model_i.prbs(4, 10);
    serializer_model_i.idle();
    pin(1'b0, 10);
    repeat (30) @(negedge core_clk);
    chk("errPinOeN", {7'h00, errPinOeN}, 8'h00);
    rd(8'h0E, 8'hFF, 8'h03);
    repeat (2) @(negedge core_clk);
    chk("errPinOeN", {7'h00, errPinOeN}, 8'h01);
    serializer_model_i.prbs(2, 3);
    serializer_model_i.idle();
    pin(1'b0, 10);
    wr(8'h04, 8'h00);
    win(0, 0, 4);
    rd(8'h0E, 8'hFF, 8'h03);
    $display("test pattern done");
    finish_test();
  end
endmodule : tb_top
